// file: shared/can_fs_pkg.sv
/*
 Shared constants for the transceiver fail-safe supervisor: operating
 modes, pin defaults, reset values and timing counts at the system clock.
 Assumes a single 250 MHz clock feeding every module that imports nothing.
*/
package can_fs_pkg;

   typedef enum logic [1:0] {MODE_SLEEP, MODE_STANDBY, MODE_RX_ONLY, MODE_NORMAL} mode_e;

   localparam int CLK_MHZ = 250;

   // Mode change window, longest time, rounds down
   localparam int MODE_WINDOW_NS = 20000;
   localparam int MODE_WINDOW_CYC = MODE_WINDOW_NS * CLK_MHZ / 1000;
   localparam int MODE_SETTLE_CYC = 64;

   // Bus silence timeout, inside its 0.6 s to 1.2 s band
   localparam int SILENCE_MIN_MS = 600;
   localparam int SILENCE_MAX_MS = 1200;
   localparam int SILENCE_MS = 900;
   localparam int SILENCE_CYC = SILENCE_MS * CLK_MHZ * 1000;

   // Clamp detection time, longest time, rounds down
   localparam int CLAMP_NS = 1800;
   localparam int CLAMP_CYC = CLAMP_NS * CLK_MHZ / 1000;

   // Filters and timeouts, least times, round up
   localparam int BUS_FILTER_NS = 1000;
   localparam int BUS_FILTER_CYC = (BUS_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int VCC_FILTER_NS = 10000;
   localparam int VCC_FILTER_CYC = (VCC_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int VCC_RECOVERY_NS = 10000;
   localparam int VCC_RECOVERY_CYC = (VCC_RECOVERY_NS * CLK_MHZ + 999) / 1000;
   localparam int TXD_TO_US = 2000;
   localparam int TXD_TO_CYC = TXD_TO_US * CLK_MHZ;
   localparam int VCC_LT_MS = 150;
   localparam int VCC_LT_CYC = VCC_LT_MS * CLK_MHZ * 1000;
   localparam int IO_LT_MS = 150;
   localparam int IO_LT_CYC = IO_LT_MS * CLK_MHZ * 1000;

   // Levels read from unconnected input pins
   localparam logic TXD_FLOAT_LVL = 1'h1;
   localparam logic EN_FLOAT_LVL = 1'h0;
   localparam logic STANDBY_SELECT_N_FLOAT_LVL = 1'h0;

   // Reset values
   localparam logic TX_EN_RST = 1'h0;
   localparam logic FAULT_N_RST = 1'h1;
   localparam logic RXD_RST = 1'h1;
   localparam mode_e MODE_RST = MODE_STANDBY;

endpackage

// file: design/hold_filter.sv
/*
 Persistence filter: flags a condition that has held for N clock cycles
 in a row; any cycle without it restarts the count.
 Assumes the condition is synchronous to clk.
*/
`timescale 1ns/100ps
module hold_filter #(
   parameter int N = 4
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cond,
   output logic done
);
   localparam int W = $clog2(N + 1);
   localparam logic [W-1:0] LIMIT = W'(N);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (!cond)
      begin
         cnt_nxt = '0;
      end
      else if (cnt_r != LIMIT)
      begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   assign done = cond && (cnt_r == LIMIT);
endmodule

// file: design/mode_sequencer.sv
/*
 Operating mode sequencer: walks to a requested or forced mode over a
 fixed settle time and reports when it leaves a low-power mode.
 Assumes requests are already filtered and synchronous to clk.
*/
`timescale 1ns/100ps
module mode_sequencer #(
   parameter int SETTLE = can_fs_pkg::MODE_SETTLE_CYC
)(
   input wire logic clk,
   input wire logic arst_n,
   input can_fs_pkg::mode_e req_mode,
   input wire logic force_sleep,
   output can_fs_pkg::mode_e mode,
   output logic busy,
   output logic wake_busy
);
   localparam int W = $clog2(SETTLE + 1);

   can_fs_pkg::mode_e mode_r, mode_nxt, target_r, target_nxt, aim;
   logic busy_r, busy_nxt, wake_r, wake_nxt;
   logic [W-1:0] cnt_r, cnt_nxt;

   always_comb
   begin
      mode_nxt = mode_r;
      target_nxt = target_r;
      busy_nxt = busy_r;
      wake_nxt = wake_r;
      cnt_nxt = cnt_r;
      aim = busy_r ? target_r : mode_r;
      if (force_sleep && aim != can_fs_pkg::MODE_SLEEP)
      begin
         target_nxt = can_fs_pkg::MODE_SLEEP;
         busy_nxt = 1'h1;
         wake_nxt = 1'h0;
         if (!busy_r)
         begin
            cnt_nxt = '0;
         end
      end
      else if (busy_r)
      begin
         if (cnt_r == W'(SETTLE - 1))
         begin
            mode_nxt = target_r;
            busy_nxt = 1'h0;
            wake_nxt = 1'h0;
         end
         else
         begin
            cnt_nxt = cnt_r + W'(1);
         end
      end
      else if (!force_sleep && req_mode != mode_r)
      begin
         target_nxt = req_mode;
         busy_nxt = 1'h1;
         cnt_nxt = '0;
         wake_nxt = (mode_r == can_fs_pkg::MODE_SLEEP || mode_r == can_fs_pkg::MODE_STANDBY)
                    && (req_mode == can_fs_pkg::MODE_NORMAL
                        || req_mode == can_fs_pkg::MODE_RX_ONLY);
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_r <= can_fs_pkg::MODE_RST;
         target_r <= can_fs_pkg::MODE_RST;
         busy_r <= 1'h0;
         wake_r <= 1'h0;
         cnt_r <= '0;
      end
      else
      begin
         mode_r <= mode_nxt;
         target_r <= target_nxt;
         busy_r <= busy_nxt;
         wake_r <= wake_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign mode = mode_r;
   assign busy = busy_r;
   assign wake_busy = wake_r;
endmodule

// file: design/can_xcvr_failsafe_supervisor.sv
/*
 Fail-safe supervisor of a CAN transceiver: supply and thermal faults,
 transmit timeout, receive clamping, forced sleep and the fault pin.
 Assumes digital comparator inputs synchronous to clk; the reset is the
 power-on reset.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - Filtered VCC low pulls fault low, active modes
// - VCC low disables transmitter until recovery filter
// - VCC long low plus silence forces sleep
// - Bus traffic during VCC low keeps mode
// - I/O supply low freezes mode and transmit inputs
// - Fault and receive outputs default high
// - I/O long low plus silence forces sleep
// - Communication: wake pattern, or long dominant
// - Floating inputs: transmit high, mode selects low
// - Transmit stuck low: transmitter off, fault low
// - Receive keeps following bus during timeout
// - Transmit rising edge releases the timeout
// - Overtemperature acts in normal mode only
// - Thermal shutdown disables transmitter, lowers fault
// - Clamp detection runs in normal mode only
// - Receive high on dominant bus sets clamp
// - Clamp keeps transmitter off and fault low
// - Receive low on dominant bus clears clamp
// - Every mode change completes inside window
// - Receive held high leaving low-power modes
// - Mode change window at most 20 us
// - Silence timeout between 0.6 and 1.2 s
// - Clamp detection time at most 1.8 us
module can_xcvr_failsafe_supervisor #(
   parameter int MODE_WINDOW_CYC = can_fs_pkg::MODE_WINDOW_CYC,
   parameter int SILENCE_CYC = can_fs_pkg::SILENCE_CYC,
   parameter int TXD_TO_CYC = can_fs_pkg::TXD_TO_CYC,
   parameter int VCC_LT_CYC = can_fs_pkg::VCC_LT_CYC,
   parameter int IO_LT_CYC = can_fs_pkg::IO_LT_CYC
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic bat_ok,
   input wire logic vcc_low,
   input wire logic io_low,
   input wire logic thermal_shutdown,
   input wire logic bus_dominant,
   input wire logic bus_wake_pattern,
   input wire logic txd,
   input wire logic txd_connected,
   input wire logic enable_sel,
   input wire logic enable_connected,
   input wire logic standby_select_n,
   input wire logic standby_connected,
   input wire logic rxd_pin,
   output logic tx_enable,
   output logic fault_indicator_n,
   output logic rxd,
   output can_fs_pkg::mode_e mode,
   output logic mode_busy,
   output logic clamp_flag,
   output logic txd_timeout_flag,
   output logic vcc_uv_flag
);
   localparam int SETTLE_MAX = can_fs_pkg::MODE_SETTLE_CYC + 2;

   logic txd_raw, en_raw, standby_select_n_raw;
   logic txd_hold_r, txd_hold_nxt, en_hold_r, en_hold_nxt, standby_select_n_hold_r, standby_select_n_hold_nxt;
   logic txd_q_r, txd_q_nxt, dom_q_r, dom_q_nxt;
   can_fs_pkg::mode_e req_mode, mode_cur;
   logic busy, wake_busy, in_normal, in_active;
   logic dom_long, bus_comm, silence_exp;
   logic vcc_low_filt, vcc_ok_filt, vcc_lt, io_lt, force_sleep;
   logic txd_low_long, txd_rise, clamp_set, clamp_clr;
   logic vcc_uv_r, vcc_uv_nxt, txto_r, txto_nxt, ot_r, ot_nxt, clamp_r, clamp_nxt;
   logic tx_en_r, tx_en_nxt, fault_n_r, fault_n_nxt, rxd_r, rxd_nxt;

   // Pulled pin levels when a pin floats
   assign txd_raw = txd_connected ? txd : can_fs_pkg::TXD_FLOAT_LVL;
   assign en_raw = enable_connected ? enable_sel : can_fs_pkg::EN_FLOAT_LVL;
   assign standby_select_n_raw = standby_connected ? standby_select_n : can_fs_pkg::STANDBY_SELECT_N_FLOAT_LVL;

   // Inputs frozen while the I/O supply is low
   always_comb
   begin
      txd_hold_nxt = txd_hold_r;
      en_hold_nxt = en_hold_r;
      standby_select_n_hold_nxt = standby_select_n_hold_r;
      if (!io_low)
      begin
         txd_hold_nxt = txd_raw;
         en_hold_nxt = en_raw;
         standby_select_n_hold_nxt = standby_select_n_raw;
      end
      txd_q_nxt = txd_hold_r;
      dom_q_nxt = dom_long;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         txd_hold_r <= can_fs_pkg::TXD_FLOAT_LVL;
         en_hold_r <= can_fs_pkg::EN_FLOAT_LVL;
         standby_select_n_hold_r <= can_fs_pkg::STANDBY_SELECT_N_FLOAT_LVL;
         txd_q_r <= can_fs_pkg::TXD_FLOAT_LVL;
         dom_q_r <= 1'h0;
      end
      else
      begin
         txd_hold_r <= txd_hold_nxt;
         en_hold_r <= en_hold_nxt;
         standby_select_n_hold_r <= standby_select_n_hold_nxt;
         txd_q_r <= txd_q_nxt;
         dom_q_r <= dom_q_nxt;
      end
   end

   // Mode request from the select pins
   always_comb
   begin
      case ({en_hold_r, standby_select_n_hold_r})
         2'h3: req_mode = can_fs_pkg::MODE_NORMAL;
         2'h1: req_mode = can_fs_pkg::MODE_RX_ONLY;
         2'h0: req_mode = can_fs_pkg::MODE_STANDBY;
         default: req_mode = can_fs_pkg::MODE_SLEEP;
      endcase
   end

   mode_sequencer #(
      .SETTLE(can_fs_pkg::MODE_SETTLE_CYC)
   ) u_mode (
      .clk(clk),
      .arst_n(arst_n),
      .req_mode(req_mode),
      .force_sleep(force_sleep),
      .mode(mode_cur),
      .busy(busy),
      .wake_busy(wake_busy)
   );

   assign in_normal = (mode_cur == can_fs_pkg::MODE_NORMAL);
   assign in_active = in_normal || (mode_cur == can_fs_pkg::MODE_RX_ONLY);

   // Bus activity and silence timeout
   hold_filter #(.N(can_fs_pkg::BUS_FILTER_CYC)) u_dom (
      .clk(clk), .arst_n(arst_n), .cond(bus_dominant), .done(dom_long));
   assign bus_comm = in_active ? (dom_long && !dom_q_r) : bus_wake_pattern;
   hold_filter #(.N(SILENCE_CYC)) u_sil (
      .clk(clk), .arst_n(arst_n), .cond(!bus_comm), .done(silence_exp));

   // Supply undervoltage filters and long-term timers
   hold_filter #(.N(can_fs_pkg::VCC_FILTER_CYC)) u_vf (
      .clk(clk), .arst_n(arst_n), .cond(vcc_low), .done(vcc_low_filt));
   hold_filter #(.N(can_fs_pkg::VCC_RECOVERY_CYC)) u_vr (
      .clk(clk), .arst_n(arst_n), .cond(!vcc_low), .done(vcc_ok_filt));
   hold_filter #(.N(VCC_LT_CYC)) u_vlt (
      .clk(clk), .arst_n(arst_n), .cond(vcc_low && bat_ok), .done(vcc_lt));
   hold_filter #(.N(IO_LT_CYC)) u_ilt (
      .clk(clk), .arst_n(arst_n), .cond(io_low && bat_ok), .done(io_lt));
   assign force_sleep = (vcc_lt || io_lt) && silence_exp;

   // Transmit timeout and clamp detection
   hold_filter #(.N(TXD_TO_CYC)) u_txto (
      .clk(clk), .arst_n(arst_n), .cond(in_normal && !txd_hold_r), .done(txd_low_long));
   assign txd_rise = txd_hold_r && !txd_q_r;
   hold_filter #(.N(can_fs_pkg::CLAMP_CYC)) u_cset (
      .clk(clk), .arst_n(arst_n), .cond(in_normal && bus_dominant && rxd_pin),
      .done(clamp_set));
   hold_filter #(.N(can_fs_pkg::CLAMP_CYC)) u_cclr (
      .clk(clk), .arst_n(arst_n), .cond(in_normal && bus_dominant && !rxd_pin),
      .done(clamp_clr));

   // Fault flags, transmitter enable, fault and receive outputs
   always_comb
   begin
      vcc_uv_nxt = vcc_uv_r;
      if (vcc_low_filt)
      begin
         vcc_uv_nxt = 1'h1;
      end
      else if (vcc_ok_filt)
      begin
         vcc_uv_nxt = 1'h0;
      end
      txto_nxt = txto_r;
      if (!in_normal)
      begin
         txto_nxt = 1'h0;
      end
      else if (txd_low_long)
      begin
         txto_nxt = 1'h1;
      end
      else if (txd_rise)
      begin
         txto_nxt = 1'h0;
      end
      ot_nxt = in_normal && thermal_shutdown;
      clamp_nxt = clamp_r;
      if (!in_normal)
      begin
         clamp_nxt = 1'h0;
      end
      else if (clamp_set)
      begin
         clamp_nxt = 1'h1;
      end
      else if (clamp_clr)
      begin
         clamp_nxt = 1'h0;
      end
      fault_n_nxt = !(in_active && vcc_uv_nxt) && !txto_nxt && !ot_nxt
                    && !clamp_nxt;
      tx_en_nxt = in_normal && !busy && !vcc_uv_nxt && !txto_nxt && !ot_nxt
                  && !clamp_nxt;
      if (wake_busy)
      begin
         rxd_nxt = 1'h1;
      end
      else if (in_active)
      begin
         rxd_nxt = !bus_dominant;
      end
      else
      begin
         rxd_nxt = can_fs_pkg::RXD_RST;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vcc_uv_r <= 1'h0;
         txto_r <= 1'h0;
         ot_r <= 1'h0;
         clamp_r <= 1'h0;
         tx_en_r <= can_fs_pkg::TX_EN_RST;
         fault_n_r <= can_fs_pkg::FAULT_N_RST;
         rxd_r <= can_fs_pkg::RXD_RST;
      end
      else
      begin
         vcc_uv_r <= vcc_uv_nxt;
         txto_r <= txto_nxt;
         ot_r <= ot_nxt;
         clamp_r <= clamp_nxt;
         tx_en_r <= tx_en_nxt;
         fault_n_r <= fault_n_nxt;
         rxd_r <= rxd_nxt;
      end
   end

   assign tx_enable = tx_en_r;
   assign fault_indicator_n = fault_n_r;
   assign rxd = rxd_r;
   assign mode = mode_cur;
   assign mode_busy = busy;
   assign clamp_flag = clamp_r;
   assign txd_timeout_flag = txto_r;
   assign vcc_uv_flag = vcc_uv_r;

   // Cycles spent in the present mode change, for the window check
   localparam int WIN_W = $clog2(MODE_WINDOW_CYC + 1);
   logic [WIN_W-1:0] win_cnt_r, win_cnt_nxt;

   always_comb
   begin
      win_cnt_nxt = '0;
      if (busy && win_cnt_r != WIN_W'(MODE_WINDOW_CYC))
      begin
         win_cnt_nxt = win_cnt_r + WIN_W'(1);
      end
      else if (busy)
      begin
         win_cnt_nxt = win_cnt_r;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         win_cnt_r <= '0;
      end
      else
      begin
         win_cnt_r <= win_cnt_nxt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   AST_VCC_FAULT: assert property (vcc_uv_r && $past(in_active) |-> !fault_n_r)
      else $error("fault pin high during filtered VCC undervoltage");
   AST_VCC_TX_OFF: assert property (vcc_uv_r |-> !tx_en_r)
      else $error("transmitter enabled during VCC undervoltage");
   AST_VCC_RECOVER: assert property ($fell(vcc_uv_r) |-> $past(vcc_ok_filt))
      else $error("VCC flag cleared without recovery filter");
   AST_FORCE_SLEEP: assert property (
      force_sleep && mode_cur != can_fs_pkg::MODE_SLEEP
      |-> ##[1:SETTLE_MAX] mode_cur == can_fs_pkg::MODE_SLEEP)
      else $error("forced sleep not reached");
   AST_KEEP_MODE: assert property (
      !busy && !silence_exp && req_mode == mode_cur |=> !busy && $stable(mode_cur))
      else $error("mode changed while bus active and request steady");
   AST_IO_BLOCK: assert property (
      io_low |=> $stable(txd_hold_r) && $stable(en_hold_r) && $stable(standby_select_n_hold_r))
      else $error("inputs taken during I/O undervoltage");
   AST_TXTO: assert property (txto_r |-> !tx_en_r && !fault_n_r)
      else $error("transmit timeout not shown");
   AST_RXD_FOLLOW: assert property (
      txto_r && $past(!wake_busy) |-> rxd_r == !$past(bus_dominant))
      else $error("receive stopped following bus during timeout");
   AST_TX_RELEASE: assert property (
      $fell(txto_r) && $past(in_normal) |-> $past(txd_rise))
      else $error("timeout released without rising transmit edge");
   AST_OT_NORMAL: assert property (ot_r |-> $past(in_normal))
      else $error("overtemperature acted outside normal mode");
   AST_OT_ACT: assert property (
      $past(thermal_shutdown && in_normal) |-> !tx_en_r && !fault_n_r)
      else $error("thermal shutdown not acted on");
   AST_CLAMP_SET: assert property (
      clamp_set |=> clamp_r && !tx_en_r && !fault_n_r)
      else $error("clamp not flagged at once");
   AST_CLAMP_CLR: assert property (
      $fell(clamp_r) |-> $past(clamp_clr || !in_normal))
      else $error("clamp cleared without cause");
   AST_MODE_WIN: assert property (
      $rose(busy) |-> ##[1:SETTLE_MAX] !busy)
      else $error("mode change exceeded window");
   AST_RXD_WAKE: assert property (wake_busy |=> rxd_r)
      else $error("receive not held high while leaving low power");
   AST_MODE_LIMIT: assert property (win_cnt_r < WIN_W'(MODE_WINDOW_CYC))
      else $error("mode change outlasted its window");
   AST_RXD_IDLE: assert property (!in_active |=> rxd_r)
      else $error("receive output low outside active modes");
   AST_CLAMP_OUT: assert property (clamp_r |-> !tx_en_r && !fault_n_r)
      else $error("clamp present with transmitter on or fault high");
   AST_FLOAT_TXD: assert property (!txd_connected && !io_low |=> txd_hold_r)
      else $error("floating transmit input not read high");
   AST_FLOAT_EN: assert property (!enable_connected && !io_low |=> !en_hold_r)
      else $error("floating enable select not read low");
   AST_FLOAT_STB: assert property (!standby_connected && !io_low |=> !standby_select_n_hold_r)
      else $error("floating standby select not read low");

   COV_TXTO: cover property ($rose(txto_r) ##[1:1000] $fell(txto_r));
   COV_CLAMP: cover property ($rose(clamp_r));
   COV_SLEEP: cover property (force_sleep ##[1:SETTLE_MAX] mode_cur == can_fs_pkg::MODE_SLEEP);
   COV_OT: cover property ($rose(ot_r));
   COV_WAKE: cover property (bus_wake_pattern && !in_active);
endmodule

// file: dv/can_ctrl_model.sv
/*
 Behavioural protocol controller at the far side of the supervisor:
 drives transmit data and the two mode-select pins from bench commands.
 Assumes the bench changes its commands at the falling clock edge.
*/
`timescale 1ns/100ps
module can_ctrl_model (
   input wire logic clk,
   input can_fs_pkg::mode_e req_mode,
   input wire logic tx_low,
   output logic txd,
   output logic enable_sel,
   output logic standby_select_n
);
   can_fs_pkg::mode_e cmd_r;
   logic tx_low_r;

   initial
   begin
      txd = 1'h1;
      enable_sel = 1'h0;
      standby_select_n = 1'h0;
      cmd_r = can_fs_pkg::MODE_STANDBY;
      tx_low_r = 1'h0;
   end

   // Commands taken at the rising edge, so falling-edge writes never race
   always @(posedge clk)
   begin
      cmd_r <= req_mode;
      tx_low_r <= tx_low;
   end

   // Pins change just after the falling edge, one cycle after a command
   always @(negedge clk)
   begin
      txd <= !tx_low_r; // Releasing the hold drives the low-to-high edge
      case (cmd_r)
         can_fs_pkg::MODE_NORMAL: {enable_sel, standby_select_n} <= 2'h3;
         can_fs_pkg::MODE_RX_ONLY: {enable_sel, standby_select_n} <= 2'h1;
         can_fs_pkg::MODE_STANDBY: {enable_sel, standby_select_n} <= 2'h0;
         default: {enable_sel, standby_select_n} <= 2'h2;
      endcase
   end
endmodule

// file: dv/can_xcvr_failsafe_supervisor_test.sv
/*
 Self-checking bench of the fail-safe supervisor with shortened timeouts.
 Assumes the controller model above and the shared package.
*/
`timescale 1ns/100ps
module can_xcvr_failsafe_supervisor_test;
   localparam int LIMIT = 30000;
   logic clk, arst_n, bat_ok, vcc_low, io_low, thermal_shutdown, bus_dominant;
   logic txd, txd_connected, enable_sel, enable_connected, standby_select_n;
   logic standby_connected, rxd_pin, clamp_hi, tx_low, bus_wake_pattern;
   logic tx_enable, fault_indicator_n, rxd, mode_busy, clamp_flag, txd_timeout_flag;
   logic vcc_uv_flag;
   can_fs_pkg::mode_e mode, req_mode;
   int mismatches, check_count, cycles;
   typedef struct {logic dom; logic hot; logic rx; logic ten; logic flt;} row_s;
   row_s rows [4] = '{'{1'h0, 1'h0, 1'h1, 1'h1, 1'h1}, '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
                      '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0}, '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1}};

   // Receive pin read-back, optionally shorted high
   assign rxd_pin = clamp_hi | rxd;

   can_ctrl_model ctrl (.clk(clk), .req_mode(req_mode), .tx_low(tx_low), .txd(txd),
      .enable_sel(enable_sel), .standby_select_n(standby_select_n));

   can_xcvr_failsafe_supervisor #(.MODE_WINDOW_CYC(100), .SILENCE_CYC(1000),
      .TXD_TO_CYC(50), .VCC_LT_CYC(100), .IO_LT_CYC(100)) DUT (
      .clk(clk), .arst_n(arst_n), .bat_ok(bat_ok), .vcc_low(vcc_low), .io_low(io_low),
      .thermal_shutdown(thermal_shutdown), .bus_dominant(bus_dominant),
      .bus_wake_pattern(bus_wake_pattern), .txd(txd), .txd_connected(txd_connected),
      .enable_sel(enable_sel), .enable_connected(enable_connected),
      .standby_select_n(standby_select_n), .standby_connected(standby_connected),
      .rxd_pin(rxd_pin), .tx_enable(tx_enable), .fault_indicator_n(fault_indicator_n),
      .rxd(rxd), .mode(mode), .mode_busy(mode_busy), .clamp_flag(clamp_flag),
      .txd_timeout_flag(txd_timeout_flag), .vcc_uv_flag(vcc_uv_flag));

   initial
   begin
      clk = 1'h0;
      forever #2 clk = !clk;
   end

   task results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles > LIMIT)
      begin
         mismatches++;
         results();
      end
   end

   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task wait_mode(input can_fs_pkg::mode_e m, input int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      check(mode, m);
   endtask

   task done(input string s);
      $display("test %s finished", s);
   endtask

   task check_reset();
      check(tx_enable, 1'h0);
      check(fault_indicator_n, 1'h1);
      check(rxd, 1'h1);
      check(mode, can_fs_pkg::MODE_STANDBY);
   endtask

   initial
   begin
      {bat_ok, vcc_low, io_low, thermal_shutdown, bus_dominant, clamp_hi, tx_low} = '0;
      bus_wake_pattern = 1'h0;
      {txd_connected, enable_connected, standby_connected} = 3'h7;
      req_mode = can_fs_pkg::MODE_STANDBY;
      mismatches = 0;
      check_count = 0;
      cycles = 0;
      arst_n = 1'h0;
      cyc(12);
      check_reset();
      arst_n = 1'h1;
      cyc(4);
      check_reset();
      done("reset");
      // Wake to normal with a dominant bus: receive must stay high meanwhile
      bus_dominant = 1'h1;
      req_mode = can_fs_pkg::MODE_NORMAL;
      cyc(4);
      check(mode_busy, 1'h1);
      check(rxd, 1'h1);
      wait_mode(can_fs_pkg::MODE_NORMAL, 80);
      bus_dominant = 1'h0;
      cyc(3);
      check(tx_enable, 1'h1);
      done("wake");
      foreach (rows[i])
      begin
         bus_dominant = rows[i].dom;
         thermal_shutdown = rows[i].hot;
         cyc(3);
         check(rxd, rows[i].rx);
         check(tx_enable, rows[i].ten);
         check(fault_indicator_n, rows[i].flt);
      end
      done("table");
      tx_low = 1'h1;
      cyc(45);
      check(tx_enable, 1'h1);
      cyc(15);
      check(tx_enable, 1'h0);
      check(fault_indicator_n, 1'h0);
      bus_dominant = 1'h1;
      cyc(3);
      check(rxd, 1'h0);
      bus_dominant = 1'h0;
      cyc(3);
      check(rxd, 1'h1);
      check(tx_enable, 1'h0);
      tx_low = 1'h0;
      cyc(5);
      check(tx_enable, 1'h1);
      check(fault_indicator_n, 1'h1);
      done("timeout");
      clamp_hi = 1'h1;
      bus_dominant = 1'h1;
      cyc(440);
      check(tx_enable, 1'h1);
      cyc(15);
      check(clamp_flag, 1'h1);
      check(tx_enable, 1'h0);
      check(fault_indicator_n, 1'h0);
      clamp_hi = 1'h0;
      cyc(440);
      check(clamp_flag, 1'h1);
      cyc(25);
      check(clamp_flag, 1'h0);
      check(tx_enable, 1'h1);
      bus_dominant = 1'h0;
      done("clamp");
      vcc_low = 1'h1;
      cyc(2490);
      check(fault_indicator_n, 1'h1);
      cyc(20);
      check(vcc_uv_flag, 1'h1);
      check(fault_indicator_n, 1'h0);
      check(tx_enable, 1'h0);
      vcc_low = 1'h0;
      cyc(2480);
      check(tx_enable, 1'h0);
      cyc(25);
      check(tx_enable, 1'h1);
      check(fault_indicator_n, 1'h1);
      done("vcc");
      req_mode = can_fs_pkg::MODE_RX_ONLY;
      wait_mode(can_fs_pkg::MODE_RX_ONLY, 80);
      {thermal_shutdown, clamp_hi, bus_dominant} = 3'h7;
      cyc(470);
      check(fault_indicator_n, 1'h1);
      check(clamp_flag, 1'h0);
      check(tx_enable, 1'h0);
      {thermal_shutdown, clamp_hi, bus_dominant} = 3'h0;
      done("rxonly");
      req_mode = can_fs_pkg::MODE_NORMAL;
      wait_mode(can_fs_pkg::MODE_NORMAL, 80);
      bat_ok = 1'h1;
      vcc_low = 1'h1;
      repeat (6)
      begin
         bus_dominant = 1'h1;
         cyc(260);
         bus_dominant = 1'h0;
         cyc(40);
      end
      check(mode, can_fs_pkg::MODE_NORMAL);
      wait_mode(can_fs_pkg::MODE_SLEEP, 1300);
      vcc_low = 1'h0;
      wait_mode(can_fs_pkg::MODE_NORMAL, 200);
      done("vcc long");
      io_low = 1'h1;
      req_mode = can_fs_pkg::MODE_STANDBY;
      cyc(50);
      check(mode_busy, 1'h0);
      check(mode, can_fs_pkg::MODE_NORMAL);
      wait_mode(can_fs_pkg::MODE_SLEEP, 1300);
      io_low = 1'h0;
      wait_mode(can_fs_pkg::MODE_STANDBY, 200);
      done("io long");
      // Wake patterns in standby keep the silence timeout from expiring
      bus_wake_pattern = 1'h1;
      cyc(1);
      bus_wake_pattern = 1'h0;
      vcc_low = 1'h1;
      repeat (3)
      begin
         cyc(400);
         bus_wake_pattern = 1'h1;
         cyc(1);
         bus_wake_pattern = 1'h0;
      end
      check(mode, can_fs_pkg::MODE_STANDBY);
      wait_mode(can_fs_pkg::MODE_SLEEP, 1300);
      vcc_low = 1'h0;
      wait_mode(can_fs_pkg::MODE_STANDBY, 200);
      done("wake pattern");
      req_mode = can_fs_pkg::MODE_NORMAL;
      wait_mode(can_fs_pkg::MODE_NORMAL, 80);
      txd_connected = 1'h0;
      tx_low = 1'h1;
      cyc(80);
      check(txd_timeout_flag, 1'h0);
      {enable_connected, standby_connected} = 2'h0;
      wait_mode(can_fs_pkg::MODE_STANDBY, 200);
      done("floating");
      arst_n = 1'h0;
      cyc(2);
      check_reset();
      arst_n = 1'h1;
      cyc(2);
      check_reset();
      done("second reset");
      results();
   end
endmodule
